// ### cvt_regs.sv
// AXI4-Lite register bank for calibration vector access and factory trims
// What this block does
// - With access enabled each vector port read returns the next of 673 calibration words.
// - With access enabled each vector port write loads the next of 673 calibration words in order.
// - The address freeze bit is only driven out on address_freeze; every access here still decodes its own address.
// - Abandoning a sequence before 673 accesses leaves the calibration data invalid.
// - After reset the gain and termination trims hold their fuse values and band-gap trim its fuse bits 3-0, all readable and writable.
// - Band-gap trim uses bits 3-0, bits 7-4 reserved and reset to zero.
// - Channel A gain trim is one 8-bit writable value.
// - Channel B gain trim is one 8-bit writable value.
// - Input A termination trim is one 8-bit writable value.
// - The vector port only moves words once the access enable bit is set.
`include "cvt_consts.svh"
module cvt_regs (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire cvt_pkg::cvt_trim_t fuse_trim,
  input  wire logic              calibration_halted_flag,
  output cvt_pkg::cvt_trim_t     trim_out,
  output logic                   cal_halt_request,
  output logic                   address_freeze,
  output logic                   vector_invalid
);
  cvt_pkg::cvt_trim_t trim;
  cvt_pkg::cvt_trim_t next_trim;
  cvt_pkg::cvt_state_t wst;
  cvt_pkg::cvt_state_t next_wst;
  cvt_pkg::cvt_state_t rst_st;
  cvt_pkg::cvt_state_t next_rst_st;
  logic        aw_held;
  logic        next_aw_held;
  logic        w_held;
  logic        next_w_held;
  logic [11:0] aw_idx;
  logic [11:0] next_aw_idx;
  logic [7:0]  w_byte;
  logic [7:0]  next_w_byte;
  logic        w_lane0;
  logic        next_w_lane0;
  logic [1:0]  bresp;
  logic [1:0]  next_bresp;
  logic [1:0]  rresp;
  logic [1:0]  next_rresp;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        rd_vec;
  logic        next_rd_vec;
  logic        access_en;
  logic        next_access_en;
  logic        freeze;
  logic        next_freeze;
  logic        halt_req;
  logic        next_halt_req;
  logic        broken;
  logic        next_broken;
  logic        fuse_load;
  logic        next_fuse_load;
  logic [9:0]  vidx;
  logic [9:0]  next_vidx;
  logic        halted;
  logic        mem_we;
  logic [7:0]  mem_q;
  logic        do_write;
  logic        do_read;
  logic [11:0] ar_idx;

  function automatic logic [11:0] word_index(input logic [31:0] addr);
    word_index = addr[`CVT_ADDR_MSB:`CVT_ADDR_LSB];
  endfunction

  function automatic logic [9:0] vec_step(input logic [9:0] idx);
    vec_step = (idx == `CVT_VEC_LAST) ? `CVT_VEC_ZERO : idx + `CVT_VEC_ONE;
  endfunction

  cvt_halt_sync u_halt_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (calibration_halted_flag),
    .sync_out (halted)
  );

  cvt_vector_mem u_vec_mem (
    .core_clk (core_clk),
    .wr_en    (mem_we),
    .wr_addr  (vidx),
    .wr_data  (w_byte),
    .rd_addr  (vidx),
    .rd_data  (mem_q)
  );

  // Write channel capture and response
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_idx  = aw_idx;
    next_w_byte  = w_byte;
    next_w_lane0 = w_lane0;
    next_wst     = wst;
    next_bresp   = bresp;
    do_write     = 1'b0;
    case (wst)
      cvt_pkg::CVT_IDLE: begin
        if (s_axi_awvalid && !aw_held) begin
          next_aw_held = 1'b1;
          next_aw_idx  = word_index(s_axi_awaddr);
        end
        if (s_axi_wvalid && !w_held) begin
          next_w_held  = 1'b1;
          next_w_byte  = s_axi_wdata[7:0];
          next_w_lane0 = s_axi_wstrb[0];
        end
        if (aw_held && w_held) begin
          do_write     = 1'b1;
          next_aw_held = 1'b0;
          next_w_held  = 1'b0;
          next_wst     = cvt_pkg::CVT_WRESP;
        end
      end
      cvt_pkg::CVT_WRESP: begin
        if (s_axi_bready) begin
          next_wst = cvt_pkg::CVT_IDLE;
        end
      end
      default: begin
        next_wst = cvt_pkg::CVT_IDLE;
      end
    endcase
    if (do_write) begin
      case (aw_idx)
        `CVT_IDX_ACCESS_EN, `CVT_IDX_VECTOR, `CVT_IDX_GAIN_A, `CVT_IDX_GAIN_B,
        `CVT_IDX_BANDGAP, `CVT_IDX_TERM_A, `CVT_IDX_CONTROL, `CVT_IDX_STATUS: begin
          next_bresp = `CVT_RESP_OKAY;
        end
        default: begin
          next_bresp = `CVT_RESP_SLVERR;
        end
      endcase
      if (aw_idx == `CVT_IDX_VECTOR && !access_en) begin
        next_bresp = `CVT_RESP_SLVERR;
      end
    end
  end

  // Read channel
  always_comb begin
    ar_idx      = word_index(s_axi_araddr);
    next_rst_st = rst_st;
    next_rdata  = rdata;
    next_rresp  = rresp;
    next_rd_vec = 1'b0;
    do_read     = 1'b0;
    case (rst_st)
      cvt_pkg::CVT_IDLE: begin
        if (s_axi_arvalid) begin
          do_read     = 1'b1;
          next_rst_st = cvt_pkg::CVT_RDATA;
          next_rresp  = `CVT_RESP_OKAY;
          next_rdata  = 32'h0000_0000;
          case (ar_idx)
            `CVT_IDX_ACCESS_EN: next_rdata[`CVT_EN_BIT] = access_en;
            `CVT_IDX_VECTOR: begin
              if (access_en) begin
                next_rd_vec = 1'b1;
              end else begin
                next_rresp = `CVT_RESP_SLVERR;
              end
            end
            `CVT_IDX_GAIN_A:  next_rdata[7:0] = trim.gain_a;
            `CVT_IDX_GAIN_B:  next_rdata[7:0] = trim.gain_b;
            `CVT_IDX_BANDGAP: next_rdata[7:0] = trim.bandgap;
            `CVT_IDX_TERM_A:  next_rdata[7:0] = trim.term_a;
            `CVT_IDX_CONTROL: begin
              next_rdata[`CVT_FREEZE_BIT] = freeze;
              next_rdata[`CVT_HALT_BIT]   = halt_req;
            end
            `CVT_IDX_STATUS: begin
              next_rdata[`CVT_ST_HALTED_BIT]              = halted;
              next_rdata[`CVT_ST_EN_BIT]                  = access_en;
              next_rdata[`CVT_ST_BROKEN_BIT]              = broken;
              next_rdata[`CVT_ST_IDX_LSB +: 10]           = vidx;
            end
            default: next_rresp = `CVT_RESP_SLVERR;
          endcase
        end
      end
      cvt_pkg::CVT_RDATA: begin
        if (rd_vec) begin
          next_rdata[7:0] = mem_q;
        end
        if (s_axi_rready && !rd_vec) begin
          next_rst_st = cvt_pkg::CVT_IDLE;
        end
      end
      default: begin
        next_rst_st = cvt_pkg::CVT_IDLE;
      end
    endcase
  end

  // Control, trims and vector index
  always_comb begin
    next_trim      = trim;
    next_access_en = access_en;
    next_freeze    = freeze;
    next_halt_req  = halt_req;
    next_broken    = broken;
    next_vidx      = vidx;
    next_fuse_load = 1'b0;
    mem_we         = 1'b0;
    if (fuse_load) begin
      next_trim         = fuse_trim;
      next_trim.bandgap = fuse_trim.bandgap & `CVT_BG_FIELD_MASK;
    end
    if (do_write && w_lane0) begin
      case (aw_idx)
        `CVT_IDX_ACCESS_EN: begin
          next_access_en = w_byte[`CVT_EN_BIT];
          if (w_byte[`CVT_EN_BIT] && !access_en) begin
            next_vidx = `CVT_VEC_ZERO;
          end
          if (!w_byte[`CVT_EN_BIT] && access_en && vidx != `CVT_VEC_ZERO) begin
            next_broken = 1'b1;
          end
        end
        `CVT_IDX_VECTOR: begin
          if (access_en) begin
            mem_we    = 1'b1;
            next_vidx = vec_step(vidx);
            if (!halted) begin
              next_broken = 1'b1;
            end else if (vidx == `CVT_VEC_LAST) begin
              next_broken = 1'b0;
            end
          end
        end
        `CVT_IDX_GAIN_A:  next_trim.gain_a  = w_byte;
        `CVT_IDX_GAIN_B:  next_trim.gain_b  = w_byte;
        `CVT_IDX_BANDGAP: next_trim.bandgap = w_byte & `CVT_BG_FIELD_MASK;
        `CVT_IDX_TERM_A:  next_trim.term_a  = w_byte;
        `CVT_IDX_CONTROL: begin
          next_freeze   = w_byte[`CVT_FREEZE_BIT];
          next_halt_req = w_byte[`CVT_HALT_BIT];
        end
        default: begin
        end
      endcase
    end
    if (do_read && next_rd_vec) begin
      next_vidx = vec_step(vidx);
      if (!halted) begin
        next_broken = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wst            <= cvt_pkg::CVT_IDLE;
      rst_st         <= cvt_pkg::CVT_IDLE;
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      aw_idx         <= 12'h000;
      w_byte         <= 8'h00;
      w_lane0        <= 1'b0;
      bresp          <= `CVT_RESP_OKAY;
      rresp          <= `CVT_RESP_OKAY;
      rdata          <= 32'h0000_0000;
      rd_vec         <= 1'b0;
      access_en      <= 1'b0;
      freeze         <= 1'b0;
      halt_req       <= 1'b0;
      broken         <= 1'b0;
      vidx           <= `CVT_VEC_ZERO;
      fuse_load      <= 1'b1;
      trim           <= '0;
      s_axi_awready  <= 1'b0;
      s_axi_wready   <= 1'b0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= `CVT_RESP_OKAY;
      s_axi_arready  <= 1'b0;
      s_axi_rvalid   <= 1'b0;
      s_axi_rresp    <= `CVT_RESP_OKAY;
      s_axi_rdata    <= 32'h0000_0000;
      trim_out       <= '0;
      cal_halt_request <= 1'b0;
      address_freeze <= 1'b0;
      vector_invalid <= 1'b0;
    end else begin
      wst            <= next_wst;
      rst_st         <= next_rst_st;
      aw_held        <= next_aw_held;
      w_held         <= next_w_held;
      aw_idx         <= next_aw_idx;
      w_byte         <= next_w_byte;
      w_lane0        <= next_w_lane0;
      bresp          <= next_bresp;
      rresp          <= next_rresp;
      rdata          <= next_rdata;
      rd_vec         <= next_rd_vec;
      access_en      <= next_access_en;
      freeze         <= next_freeze;
      halt_req       <= next_halt_req;
      broken         <= next_broken;
      vidx           <= next_vidx;
      fuse_load      <= next_fuse_load;
      trim           <= next_trim;
      s_axi_awready  <= next_aw_held && !aw_held;
      s_axi_wready   <= next_w_held && !w_held;
      s_axi_bvalid   <= next_wst == cvt_pkg::CVT_WRESP;
      s_axi_bresp    <= next_bresp;
      s_axi_arready  <= do_read;
      s_axi_rvalid   <= next_rst_st == cvt_pkg::CVT_RDATA && !next_rd_vec;
      s_axi_rresp    <= next_rresp;
      s_axi_rdata    <= next_rdata;
      trim_out       <= next_trim;
      cal_halt_request <= next_halt_req;
      address_freeze <= next_freeze;
      vector_invalid <= next_broken;
    end
  end
endmodule

// ### cvt_consts.svh
// Register offsets, field positions and counts for the calibration and trim register bank
`ifndef CVT_CONSTS_SVH
`define CVT_CONSTS_SVH
`define CVT_IDX_ACCESS_EN   12'h070
`define CVT_IDX_VECTOR      12'h071
`define CVT_IDX_GAIN_A      12'h07A
`define CVT_IDX_GAIN_B      12'h07B
`define CVT_IDX_BANDGAP     12'h07C
`define CVT_IDX_TERM_A      12'h07E
`define CVT_IDX_CONTROL     12'h080
`define CVT_IDX_STATUS      12'h081
`define CVT_ADDR_LSB        2
`define CVT_ADDR_MSB        13
`define CVT_VEC_WORDS       10'd673
`define CVT_VEC_LAST        10'd672
`define CVT_VEC_ZERO        10'h000
`define CVT_VEC_ONE         10'h001
`define CVT_BG_FIELD_MASK   8'h0F
`define CVT_EN_BIT          0
`define CVT_FREEZE_BIT      0
`define CVT_HALT_BIT        1
`define CVT_ST_HALTED_BIT   0
`define CVT_ST_EN_BIT       1
`define CVT_ST_BROKEN_BIT   2
`define CVT_ST_IDX_LSB      16
`define CVT_RESP_OKAY       2'h0
`define CVT_RESP_SLVERR     2'h2
`endif

// ### cvt_pkg.sv
// Types shared by the calibration and trim register bank
package cvt_pkg;
  typedef struct packed {
    logic [7:0] gain_a;
    logic [7:0] gain_b;
    logic [7:0] bandgap;
    logic [7:0] term_a;
  } cvt_trim_t;
  typedef enum logic [1:0] {
    CVT_IDLE  = 2'b00,
    CVT_WRESP = 2'b01,
    CVT_RDATA = 2'b10
  } cvt_state_t;
endpackage

// ### cvt_vector_mem.sv
// Calibration vector store, one word per index, registered read
module cvt_vector_mem (
  input  wire logic       core_clk,
  input  wire logic       wr_en,
  input  wire logic [9:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [9:0] rd_addr,
  output logic      [7:0] rd_data
);
  logic [7:0] mem [0:1023];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ### cvt_halt_sync.sv
// Three-stage synchroniser for the calibration halted level
module cvt_halt_sync (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);
  logic s1;
  logic s2;
  logic s3;
  logic next_out;

  always_comb begin
    next_out = sync_out;
    if (s2 == s3) begin
      next_out = s3;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1       <= 1'b0;
      s2       <= 1'b0;
      s3       <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1       <= async_in;
      s2       <= s1;
      s3       <= s2;
      sync_out <= next_out;
    end
  end
endmodule

// ### cvt_regs_monitor.sv
// Concurrent checks on the ports of the calibration and trim register bank
`include "cvt_consts.svh"
module cvt_regs_monitor (
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic [1:0]         s_axi_rresp,
  input wire logic               s_axi_rvalid,
  input wire cvt_pkg::cvt_trim_t fuse_trim,
  input wire cvt_pkg::cvt_trim_t trim_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking mon_cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_bg_reserved_zero: assert property (trim_out.bandgap[7:4] == 4'h0)
    else $error("bandgap reserved bits not zero");
  chk_fuse_load: assert property ($rose(rst_n) |-> ##[1:2] trim_out == (fuse_trim & 32'hFFFF0FFF))
    else $error("trims not loaded from fuses");
  chk_trim_change_cause: assert property ($changed(trim_out) |-> s_axi_bvalid || $past(s_axi_bvalid) || !$past(rst_n, 2))
    else $error("trim changed without a write");
  chk_bvalid_cause: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready) || $past(s_axi_wready))
    else $error("write response without capture");
  chk_write_single: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready longer than one cycle");
  chk_read_latency: assert property ($rose(s_axi_arready) |-> ##[0:2] s_axi_rvalid)
    else $error("read data late");
  chk_read_single: assert property (s_axi_rvalid |=> !s_axi_arready)
    else $error("read taken while data pending");
  chk_refused_data_zero: assert property (s_axi_rvalid && s_axi_rresp == `CVT_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  cov_read_refused: cover property (s_axi_rvalid && s_axi_rresp == `CVT_RESP_SLVERR);
  cov_write_refused: cover property (s_axi_bvalid && s_axi_bresp == `CVT_RESP_SLVERR);
  cov_trim_written: cover property ($changed(trim_out) && s_axi_bvalid);
endmodule

// ### tb_top.sv
// Self-checking bench for the calibration and trim register bank
`include "cvt_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic               core_clk = 1'h0;
  logic               rst_n = 1'h0;
  logic [31:0]        s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0]         s_axi_wstrb = 4'hF;
  logic               s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic               s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, calibration_halted_flag = 1'h0;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic               cal_halt_request, address_freeze, vector_invalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  cvt_pkg::cvt_trim_t fuse_trim = 32'hA53CF95E;
  cvt_pkg::cvt_trim_t trim_out;
  logic [11:0]        ti [4] = '{`CVT_IDX_GAIN_A, `CVT_IDX_GAIN_B, `CVT_IDX_BANDGAP, `CVT_IDX_TERM_A};
  logic [7:0]         fe [4] = '{8'hA5, 8'h3C, 8'h09, 8'h5E};
  logic [7:0]         wp [4] = '{8'h81, 8'h42, 8'hF3, 8'h24};
  logic [7:0]         we [4] = '{8'h81, 8'h42, 8'h03, 8'h24};
  logic [31:0]        d;
  logic [1:0]         r;
  int                 fail_count = 0, checked = 0, cyc = 0;
  cvt_regs cvt_regs_inst (.*);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict;
    end
  end
  task automatic print_verdict;
    $display("Checked %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] v, output logic [1:0] resp);
    @(posedge core_clk);
    s_axi_awaddr <= {18'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] idx, output logic [31:0] v, output logic [1:0] resp);
    @(posedge core_clk);
    s_axi_araddr <= {18'h0, idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic wchk(input logic [11:0] idx, input logic [7:0] v, input logic [1:0] er);
    logic [1:0] resp;
    wr(idx, v, resp);
    chk({30'h0, resp}, {30'h0, er});
  endtask
  task automatic rchk(input logic [11:0] idx, input logic [7:0] ev, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0]  resp;
    rd(idx, v, resp);
    chk(v, {24'h0, ev});
    chk({30'h0, resp}, {30'h0, er});
  endtask
  function automatic logic [7:0] vd(input int i);
    return i[7:0] * 8'h1D ^ 8'h5A;
  endfunction
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge core_clk);
    chk(trim_out, 32'hA53C095E);
    for (int k = 0; k < 4; k++) rchk(ti[k], fe[k], `CVT_RESP_OKAY);
    $display("test fuse_values done");
    for (int k = 0; k < 4; k++) wchk(ti[k], wp[k], `CVT_RESP_OKAY);
    for (int k = 0; k < 4; k++) rchk(ti[k], we[k], `CVT_RESP_OKAY);
    chk(trim_out, 32'h81420324);
    $display("test trim_write done");
    rchk(12'h07D, 8'h00, `CVT_RESP_SLVERR);
    wchk(12'h07D, 8'hFF, `CVT_RESP_SLVERR);
    chk(trim_out, 32'h81420324);
    rchk(`CVT_IDX_VECTOR, 8'h00, `CVT_RESP_SLVERR);
    wchk(`CVT_IDX_VECTOR, 8'h11, `CVT_RESP_SLVERR);
    $display("test refused done");
    calibration_halted_flag <= 1'h1;
    wchk(`CVT_IDX_CONTROL, 8'h03, `CVT_RESP_OKAY);
    chk({30'h0, address_freeze, cal_halt_request}, 32'h3);
    wchk(`CVT_IDX_ACCESS_EN, 8'h01, `CVT_RESP_OKAY);
    for (int i = 0; i < 3; i++) rd(`CVT_IDX_VECTOR, d, r);
    rd(`CVT_IDX_STATUS, d, r);
    chk(d, 32'h0003_0003);
    wchk(`CVT_IDX_ACCESS_EN, 8'h00, `CVT_RESP_OKAY);
    chk({31'h0, vector_invalid}, 32'h1);
    $display("test abandon done");
    wchk(`CVT_IDX_ACCESS_EN, 8'h01, `CVT_RESP_OKAY);
    for (int i = 0; i < 673; i++) wchk(`CVT_IDX_VECTOR, vd(i), `CVT_RESP_OKAY);
    chk({31'h0, vector_invalid}, 32'h0);
    for (int i = 0; i < 673; i++) rchk(`CVT_IDX_VECTOR, vd(i), `CVT_RESP_OKAY);
    rchk(`CVT_IDX_VECTOR, vd(0), `CVT_RESP_OKAY);
    $display("test restore_readback done");
    calibration_halted_flag <= 1'h0;
    repeat (6) @(posedge core_clk);
    rd(`CVT_IDX_VECTOR, d, r);
    chk({31'h0, vector_invalid}, 32'h1);
    calibration_halted_flag <= 1'h1;
    repeat (6) @(posedge core_clk);
    wchk(`CVT_IDX_ACCESS_EN, 8'h00, `CVT_RESP_OKAY);
    wchk(`CVT_IDX_ACCESS_EN, 8'h01, `CVT_RESP_OKAY);
    rchk(`CVT_IDX_VECTOR, vd(0), `CVT_RESP_OKAY);
    $display("test not_halted_and_restart done");
    print_verdict;
  end
endmodule
bind cvt_regs cvt_regs_monitor cvt_regs_monitor_inst (.*);
